// [lbm_pkg.sv]
package lbm_pkg;
    localparam int XLEN = 64;
    // slb entry index field: bits 52..63 of index_gpr (big-endian) = low 12 bits
    localparam int SLB_IDX_W = 12;
    localparam int SLB_IDX_LSB = 0;
    // effective_segment_id is bits 0..35 (msb-first) = [63:28]
    localparam int EFFECTIVE_SEGMENT_ID_W = 36;
    localparam int EFFECTIVE_SEGMENT_ID_LSB = 28;
    // valid flag sits at big-endian bit 36 = [27]
    localparam int VBIT_POS = 27;
    // source_gpr layout: virtual_segment_id [63:12], ks [11], kp [10], n [9], l [8], c [7]
    localparam int VIRTUAL_SEGMENT_ID_W = 52;
    localparam int VIRTUAL_SEGMENT_ID_LSB = 12;
    localparam int KS_POS = 11;
    localparam int KP_POS = 10;
    localparam int NX_POS = 9;
    localparam int LP_POS = 8;
    localparam int CLS_POS = 7;
    // virtual page number from index_gpr [63:12]
    localparam int VPN_W = 52;
    localparam int VPN_LSB = 12;
    // interrupt status bit positions
    localparam int EV_W = 4;
    localparam int EV_PRIV = 0;
    localparam int EV_TLBIA = 1;
    localparam int EV_SYNC = 2;
    localparam int EV_ILLEGAL = 3;
    // register port offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CLEAR = 4'h1;
    localparam logic [3:0] REG_ENABLE = 4'h2;
    localparam logic [3:0] REG_CONFIG = 4'h3;
    localparam logic [3:0] REG_PENDING = 4'h4;
    // config bits: tlb present, illegal (vs no-op) when absent, local large pages
    localparam int CFG_W = 3;
    localparam int CFG_TLB_PRESENT = 0;
    localparam int CFG_ABSENT_ILLEGAL = 1;
    localparam int CFG_LOCAL_LARGE = 2;
    localparam logic [CFG_W-1:0] CFG_RESET = 3'b101;

    typedef enum logic [7:0] {
        OP_NONE = 8'h00,
        OP_SLB_WRITE = 8'h01,
        OP_SLB_READ_V = 8'h02,
        OP_SLB_READ_E = 8'h03,
        OP_TLBI_GLOBAL = 8'h04,
        OP_TLBI_LOCAL = 8'h05,
        OP_TLBI_ALL = 8'h06,
        OP_TLB_SYNC = 8'h07
    } op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_BCAST = 4'b0010,
        ST_SYNC = 4'b0100,
        ST_DONE = 4'b1000
    } state_t;
endpackage : lbm_pkg

// [slb_store.sv]
`timescale 1ns/1ns
module slb_store
    import lbm_pkg::*;
#(
    parameter int ENTRIES = 64
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    // write port
    input wire logic i_wr,
    input wire logic [SLB_IDX_W-1:0] i_wr_idx,
    input wire logic [XLEN-1:0] i_wr_virtual_segment_id_word,
    input wire logic [EFFECTIVE_SEGMENT_ID_W:0] i_wr_effective_segment_id_v,
    // read port, combinational
    input wire logic [SLB_IDX_W-1:0] i_rd_idx,
    output logic [XLEN-1:0] o_rd_virtual_segment_id_word,
    output logic [EFFECTIVE_SEGMENT_ID_W:0] o_rd_effective_segment_id_v
);
    logic [XLEN-1:0] virtual_segment_id_mem [ENTRIES];
    logic [EFFECTIVE_SEGMENT_ID_W-1:0] effective_segment_id_mem [ENTRIES];
    logic [ENTRIES-1:0] valid;
    logic hit;

    assign hit = i_rd_idx < SLB_IDX_W'(ENTRIES);

    // entries outside the implemented range read as invalid
    always_comb begin
        o_rd_virtual_segment_id_word = '0;
        o_rd_effective_segment_id_v = '0;
        if (hit) begin
            o_rd_virtual_segment_id_word = virtual_segment_id_mem[i_rd_idx[$clog2(ENTRIES)-1:0]];
            o_rd_effective_segment_id_v = {effective_segment_id_mem[i_rd_idx[$clog2(ENTRIES)-1:0]],
                           valid[i_rd_idx[$clog2(ENTRIES)-1:0]]};
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_wr && i_wr_idx < SLB_IDX_W'(ENTRIES)) begin
            virtual_segment_id_mem[i_wr_idx[$clog2(ENTRIES)-1:0]] <= i_wr_virtual_segment_id_word;
            effective_segment_id_mem[i_wr_idx[$clog2(ENTRIES)-1:0]] <= i_wr_effective_segment_id_v[EFFECTIVE_SEGMENT_ID_W:1];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            valid <= '0;
        end else if (i_wr && i_wr_idx < SLB_IDX_W'(ENTRIES)) begin
            valid[i_wr_idx[$clog2(ENTRIES)-1:0]] <= i_wr_effective_segment_id_v[0];
        end
    end
endmodule : slb_store

// [lookaside_buffer_maintenance.sv]
`timescale 1ns/1ns
// Behaviour
// - slb write picks the entry by index_gpr bits 52..63 and fills it from source_gpr and index_gpr bits 0..36.
// - slb write never invalidates; its valid bit comes only from the written data.
// - first slb read returns virtual_segment_id, both keys, no-execute, large-page and class of a valid entry.
// - second slb read returns effective_segment_id and valid bit of a valid entry.
// - global invalidate takes the page number from index_gpr; size 0 means 4KB pages, else large.
// - global invalidate reaches the tlbs of every processor, so it is broadcast.
// - global invalidate is ordered like a caching-inhibited guarded data access.
// - local invalidate touches only this processor and completes without broadcast.
// - large-page targeting by local invalidate is optional and may be switched off.
// - invalidate-all clears every tlb entry whatever the translate bits say.
// - invalidate-all sends nothing to other processors.
// - tlb sync waits until all earlier global invalidates are acknowledged everywhere.
// - every operation here is supervisor only; tlb operations are optional.
// - without a tlb the tlb operations act as no-ops or illegal instructions.
module lookaside_buffer_maintenance
    import lbm_pkg::*;
#(
    parameter int SLB_ENTRIES = 64,
    parameter int MAX_OUTSTANDING = 15
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // pipeline request
    input wire logic i_req,
    input wire logic [7:0] i_op,
    input wire logic [XLEN-1:0] i_source_gpr,
    input wire logic [XLEN-1:0] i_index_gpr,
    input wire logic i_large_page,
    input wire logic i_supervisor,
    input wire logic i_wide_mode_bit,
    input wire logic i_instr_translate_on,
    input wire logic i_data_translate_on,
    // pipeline answer
    output logic o_busy,
    output logic o_done,
    output logic [XLEN-1:0] o_result,
    output logic o_result_valid,
    output logic o_priv_exception,
    output logic o_illegal_exception,
    output logic o_ordered_access,
    // local tlb
    output logic o_tlb_inval,
    output logic [VPN_W-1:0] o_tlb_vpn,
    output logic o_tlb_large,
    output logic o_tlb_inval_all,
    // broadcast to other processors
    output logic o_bcast_inval,
    output logic [VPN_W-1:0] o_bcast_vpn,
    output logic o_bcast_large,
    input wire logic i_bcast_ack,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq
);
    state_t state;
    state_t next_state;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] enable;
    logic [EV_W-1:0] events;
    logic [CFG_W-1:0] cfg;
    logic [4:0] pending;
    logic [XLEN-1:0] rd_virtual_segment_id_word;
    logic [EFFECTIVE_SEGMENT_ID_W:0] rd_effective_segment_id_v;
    logic accept;
    logic privileged_ok;
    logic is_tlb_op;
    logic tlb_absent;
    logic slb_wr;
    logic issue_global;
    logic ack_seen;
    logic pending_full;
    logic [EV_W-1:0] next_status;
    logic [31:0] read_word;
    logic [SLB_IDX_W-1:0] slb_idx;
    logic [VPN_W-1:0] virtual_page_number;
    op_t op;

    assign op = op_t'(i_op);
    // busy also covers a full counter, so one more global cannot wrap it
    assign accept = i_req && state == ST_IDLE && !o_busy;
    assign pending_full = pending >= 5'(MAX_OUTSTANDING);
    assign slb_idx = i_index_gpr[SLB_IDX_LSB +: SLB_IDX_W];
    assign virtual_page_number = i_index_gpr[VPN_LSB +: VPN_W];
    assign privileged_ok = i_supervisor;
    assign is_tlb_op = op inside {OP_TLBI_GLOBAL, OP_TLBI_LOCAL, OP_TLBI_ALL, OP_TLB_SYNC};
    assign tlb_absent = !cfg[CFG_TLB_PRESENT];
    // a write only stores; the valid bit is whatever software put in index_gpr
    assign slb_wr = accept && privileged_ok && op == OP_SLB_WRITE;
    // outside wide mode the outcome is left to software; the global form runs unchanged
    assign issue_global = accept && privileged_ok && op == OP_TLBI_GLOBAL && !tlb_absent;
    assign ack_seen = i_bcast_ack && pending != '0;

    slb_store #(
        .ENTRIES(SLB_ENTRIES)
    ) u_slb (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_wr(slb_wr),
        .i_wr_idx(slb_idx),
        .i_wr_virtual_segment_id_word(i_source_gpr),
        .i_wr_effective_segment_id_v(i_index_gpr[EFFECTIVE_SEGMENT_ID_LSB+EFFECTIVE_SEGMENT_ID_W-1:VBIT_POS]),
        .i_rd_idx(slb_idx),
        .o_rd_virtual_segment_id_word(rd_virtual_segment_id_word),
        .o_rd_effective_segment_id_v(rd_effective_segment_id_v)
    );

    // global invalidates are held while a sync waits; they complete without waiting for their ack
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (accept && privileged_ok && !(is_tlb_op && tlb_absent)) begin
                    if (op == OP_TLBI_GLOBAL) begin
                        next_state = ST_BCAST;
                    end else if (op == OP_TLB_SYNC) begin
                        next_state = ST_SYNC;
                    end else begin
                        next_state = ST_DONE;
                    end
                end else if (accept) begin
                    next_state = ST_DONE;
                end
            end
            ST_BCAST: next_state = ST_DONE;
            ST_SYNC: begin
                if (pending == '0 || (pending == 5'h1 && i_bcast_ack)) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // outstanding global invalidates; stall issue when the counter is full
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            pending <= '0;
        end else if (issue_global && !ack_seen) begin
            pending <= pending + 5'h1;
        end else if (!issue_global && ack_seen) begin
            pending <= pending - 5'h1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= next_state != ST_IDLE || pending_full;
        end
    end

    // pipeline answers, one cycle after acceptance; done comes later for global invalidate and sync
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_done <= 1'b0;
            o_result <= '0;
            o_result_valid <= 1'b0;
            o_priv_exception <= 1'b0;
            o_illegal_exception <= 1'b0;
            o_ordered_access <= 1'b0;
        end else begin
            o_done <= (accept && next_state == ST_DONE) || (state != ST_IDLE
                      && state != ST_DONE && next_state == ST_DONE);
            o_result_valid <= 1'b0;
            o_priv_exception <= accept && !privileged_ok;
            o_illegal_exception <= accept && privileged_ok && is_tlb_op && tlb_absent
                                   && cfg[CFG_ABSENT_ILLEGAL];
            o_ordered_access <= accept && privileged_ok && !tlb_absent
                                && (op == OP_TLBI_GLOBAL || op == OP_TLB_SYNC);
            if (accept && privileged_ok && op == OP_SLB_READ_V) begin
                o_result_valid <= 1'b1;
                o_result <= '0;
                if (rd_effective_segment_id_v[0]) begin
                    o_result <= rd_virtual_segment_id_word & {{VIRTUAL_SEGMENT_ID_W{1'b1}}, 5'h1f, 7'h00};
                end
            end else if (accept && privileged_ok && op == OP_SLB_READ_E) begin
                o_result_valid <= 1'b1;
                o_result <= '0;
                if (rd_effective_segment_id_v[0]) begin
                    o_result <= {rd_effective_segment_id_v, {VBIT_POS{1'b0}}};
                end
            end
        end
    end

    // local tlb strobes
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_tlb_inval <= 1'b0;
            o_tlb_vpn <= '0;
            o_tlb_large <= 1'b0;
            o_tlb_inval_all <= 1'b0;
        end else begin
            o_tlb_inval <= 1'b0;
            o_tlb_inval_all <= 1'b0;
            if (accept && privileged_ok && !tlb_absent) begin
                if (op == OP_TLBI_GLOBAL || op == OP_TLBI_LOCAL) begin
                    o_tlb_inval <= 1'b1;
                    o_tlb_vpn <= virtual_page_number;
                    o_tlb_large <= i_large_page
                                   && (op == OP_TLBI_GLOBAL || cfg[CFG_LOCAL_LARGE]);
                end
                // translate enables deliberately ignored
                o_tlb_inval_all <= op == OP_TLBI_ALL;
            end
        end
    end

    // broadcast only for the global form
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_bcast_inval <= 1'b0;
            o_bcast_vpn <= '0;
            o_bcast_large <= 1'b0;
        end else begin
            o_bcast_inval <= issue_global;
            if (issue_global) begin
                o_bcast_vpn <= virtual_page_number;
                o_bcast_large <= i_large_page;
            end
        end
    end

    assign events[EV_PRIV] = accept && !privileged_ok;
    assign events[EV_TLBIA] = accept && privileged_ok && !tlb_absent && op == OP_TLBI_ALL;
    assign events[EV_SYNC] = state == ST_SYNC && next_state == ST_DONE;
    assign events[EV_ILLEGAL] = accept && privileged_ok && is_tlb_op && tlb_absent
                                && cfg[CFG_ABSENT_ILLEGAL];

    // one sticky flag per event; a set wins over a clear in the same cycle
    for (genvar b = 0; b < EV_W; b++) begin : g_flag
        assign next_status[b] = events[b]
                                || (status[b] && !(i_wr && i_addr == REG_CLEAR && i_wdata[b]));
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            enable <= '0;
            cfg <= CFG_RESET;
        end else if (i_wr && i_addr == REG_ENABLE) begin
            enable <= i_wdata[EV_W-1:0];
        end else if (i_wr && i_addr == REG_CONFIG) begin
            cfg <= i_wdata[CFG_W-1:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status & enable);
        end
    end

    // the write-only clear register and unmapped offsets read as zero
    always_comb begin
        read_word = '0;
        unique case (i_addr)
            REG_STATUS: read_word = {28'h000_0000, status};
            REG_ENABLE: read_word = {28'h000_0000, enable};
            REG_CONFIG: read_word = {29'h000_0000, cfg};
            REG_PENDING: read_word = {27'h0, pending};
            default: read_word = '0;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? read_word : 32'h0000_0000;
        end
    end
endmodule : lookaside_buffer_maintenance

// [lbm_assertions.sv]
`timescale 1ns/1ns
module lbm_assertions
    import lbm_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // request side
    input wire logic i_req,
    input wire logic [7:0] i_op,
    input wire logic [XLEN-1:0] i_index_gpr,
    input wire logic i_large_page,
    input wire logic i_supervisor,
    input wire logic i_bcast_ack,
    input wire logic i_wr,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    // answer side
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_result_valid,
    input wire logic o_priv_exception,
    input wire logic o_illegal_exception,
    input wire logic o_ordered_access,
    input wire logic o_tlb_inval,
    input wire logic o_tlb_large,
    input wire logic o_tlb_inval_all,
    input wire logic o_bcast_inval,
    input wire logic o_bcast_large,
    input wire logic [VPN_W-1:0] o_bcast_vpn
);
    logic [2:0] cfg;
    logic [4:0] pend;
    logic in_sync;
    logic take;
    logic go;
    assign take = i_req && !o_busy && i_supervisor;
    assign go = take && cfg[0];
    // shadow of the config register: which tlb ops are live decides what to expect
    always_ff @(posedge i_clock) begin
        if (!i_rstn) cfg <= CFG_RESET;
        else if (i_wr && i_addr == REG_CONFIG) cfg <= i_wdata[2:0];
    end
    always_ff @(posedge i_clock) begin
        if (!i_rstn) pend <= 5'h00;
        else pend <= pend + 5'(o_bcast_inval) - 5'(i_bcast_ack);
    end
    always_ff @(posedge i_clock) begin
        if (!i_rstn) in_sync <= 1'h0;
        else if (go && i_op == OP_TLB_SYNC) in_sync <= 1'h1;
        else if (o_done) in_sync <= 1'h0;
    end
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    priv_blocks_a: assert property (
        i_req && !o_busy && !i_supervisor && cfg[0] && i_op inside {[8'h01:8'h07]} |=>
        o_priv_exception && o_done && !o_tlb_inval && !o_tlb_inval_all && !o_bcast_inval)
        else $error("privileged op had an effect");
    global_bcast_a: assert property (
        go && i_op == OP_TLBI_GLOBAL |=> o_bcast_inval && o_tlb_inval && o_ordered_access
        && {12'h000, o_bcast_vpn} == $past(i_index_gpr) >> VPN_LSB
        && o_bcast_large == $past(i_large_page) ##1 o_done)
        else $error("global invalidate not broadcast");
    local_only_a: assert property (
        go && i_op == OP_TLBI_LOCAL |=> o_tlb_inval && !o_bcast_inval && o_done
        && o_tlb_large == ($past(i_large_page) && cfg[2]))
        else $error("local invalidate wrong");
    all_local_a: assert property (
        go && i_op == OP_TLBI_ALL |=> o_tlb_inval_all && o_done && !o_bcast_inval)
        else $error("invalidate all wrong");
    sync_wait_a: assert property (
        in_sync && o_done |-> pend == 5'h00)
        else $error("sync ended with invalidates pending");
    sync_bound_a: assert property (
        go && i_op == OP_TLB_SYNC && pend == 5'h00 |-> ##[1:3] o_ordered_access ##[0:3] o_done)
        else $error("idle sync did not finish");
    absent_illegal_a: assert property (
        take && cfg[1:0] == 2'h2 && i_op inside {[8'h04:8'h07]} |=>
        o_illegal_exception && o_done && !o_tlb_inval && !o_tlb_inval_all && !o_bcast_inval)
        else $error("absent tlb op not illegal");
    read_answer_a: assert property (
        take && (i_op == OP_SLB_READ_V || i_op == OP_SLB_READ_E) |=> o_result_valid && o_done)
        else $error("slb read gave no result");
endmodule : lbm_assertions

// [tlb_peers.sv]
`timescale 1ns/1ns
module tlb_peers (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_inval,
    input wire logic [7:0] i_delay,
    output logic o_ack
);
    int due[$];
    int now = 0;
    // peers finish in issue order, one ack a cycle at most, i_delay cycles late
    always @(posedge i_clock) begin
        now = now + 1;
        o_ack <= 1'h0;
        if (!i_rstn) due.delete();
        else begin
            if (i_inval) due.push_back(now + int'(i_delay));
            if (due.size() > 0 && due[0] <= now) begin
                void'(due.pop_front());
                o_ack <= 1'h1;
            end
        end
    end
endmodule : tlb_peers

// [lookaside_buffer_maintenance_tb.sv]
`timescale 1ns/1ns
module lookaside_buffer_maintenance_tb
    import lbm_pkg::*;
;
    logic i_clock = 1'h0;
    logic i_rstn = 1'h0;
    logic i_req = 1'h0;
    logic [7:0] i_op = 8'h00;
    logic [XLEN-1:0] i_source_gpr = '0;
    logic [XLEN-1:0] i_index_gpr = '0;
    logic i_large_page = 1'h0;
    logic i_supervisor = 1'h1;
    logic i_wide_mode_bit = 1'h1;
    logic i_instr_translate_on = 1'h0;
    logic i_data_translate_on = 1'h0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = '0;
    logic i_wr = 1'h0;
    logic i_rd = 1'h0;
    logic o_busy, o_done, o_result_valid, o_priv_exception, o_illegal_exception, o_irq;
    logic o_ordered_access, o_tlb_inval, o_tlb_large, o_tlb_inval_all, o_bcast_inval;
    logic o_bcast_large, i_bcast_ack;
    logic [XLEN-1:0] o_result;
    logic [VPN_W-1:0] o_tlb_vpn, o_bcast_vpn;
    logic [31:0] o_rdata;
    logic [7:0] delay = 8'h03;
    logic [63:0] got;
    logic [63:0] m_vw [64];
    logic [36:0] m_ev [64];
    int idx_q[$];
    int err_total = 0;
    int comparisons = 0;
    int k;
    lookaside_buffer_maintenance uut (.*);
    tlb_peers peers (.i_clock, .i_rstn, .i_inval(o_bcast_inval), .i_delay(delay),
        .o_ack(i_bcast_ack));
    initial forever #25 i_clock = ~i_clock;
    task automatic chk_result(input logic [63:0] g, input logic [63:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk_result
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        chk_result({32'h0, g}, {32'h0, e});
    endtask : chk_reg
    task automatic run_op(input logic [7:0] op, input logic [63:0] s, input logic [63:0] x,
                          input logic lg, input logic sup);
        int n;
        @(posedge i_clock);
        i_req <= 1'h1;
        i_op <= op;
        i_source_gpr <= s;
        i_index_gpr <= x;
        i_large_page <= lg;
        i_supervisor <= sup;
        i_instr_translate_on <= 1'($urandom);
        i_data_translate_on <= 1'($urandom);
        @(posedge i_clock);
        i_req <= 1'h0;
        n = 0;
        #1;
        while (o_done !== 1'h1 && n < 300) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        chk_result({63'h0, o_done}, 64'h1);
        chk_result({63'h0, o_busy}, 64'h1);
        got = o_result;
    endtask : run_op
    task automatic slb_put(input logic [63:0] s, input logic [63:0] x, input logic sup);
        run_op(OP_SLB_WRITE, s, x, 1'h0, sup);
        if (sup && x[11:0] < 12'h040) begin
            m_vw[x[5:0]] = s;
            m_ev[x[5:0]] = x[63:27];
        end
    endtask : slb_put
    task automatic slb_check(input int i);
        logic v;
        v = 1'h0;
        if (i < 64) v = (m_ev[i][0] === 1'h1);
        run_op(OP_SLB_READ_V, '0, 64'(i), 1'h0, 1'h1);
        chk_result(got, v ? (m_vw[i] >> CLS_POS) << CLS_POS : 64'h0);
        run_op(OP_SLB_READ_E, '0, 64'(i), 1'h0, 1'h1);
        chk_result(got, v ? 64'(m_ev[i]) << VBIT_POS : 64'h0);
    endtask : slb_check
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'h0;
    endtask : reg_wr
    task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_clock);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'h0;
        #1;
        chk_reg(o_rdata, e);
    endtask : reg_read
    task automatic irq_chk(input logic e);
        repeat (2) @(posedge i_clock);
        #1;
        chk_reg({31'h0, o_irq}, {31'h0, e});
    endtask : irq_chk
    task automatic complete_run();
        $display("compared %0d, mismatched %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (5000) @(posedge i_clock);
        err_total++;
        complete_run();
    end
    initial begin
        logic [63:0] x;
        void'($urandom(32'hc979_be7d));
        repeat (2) @(posedge i_clock);
        i_rstn <= 1'h1;
        reg_read(REG_STATUS, 32'h0);
        reg_read(REG_ENABLE, 32'h0);
        reg_read(REG_CONFIG, 32'h0000_0005);
        reg_read(REG_PENDING, 32'h0);
        reg_read(4'hf, 32'h0);
        $display("test reset done");
        for (k = 0; k < 8; k++) begin
            x = {$urandom, $urandom};
            x[11:0] = (k == 0) ? 12'h03f : 12'(k * 5);
            x[27] = (k != 7);
            idx_q.push_back(int'(x[11:0]));
            slb_put({$urandom, $urandom}, x, 1'h1);
        end
        // out-of-range index and a problem-state write must leave the entries alone
        slb_put({$urandom, $urandom}, 64'h0000_0000_0800_0040, 1'h1);
        slb_put({$urandom, $urandom}, 64'h0000_0000_0800_0005, 1'h0);
        idx_q.push_back(64);
        foreach (idx_q[j]) slb_check(idx_q[j]);
        reg_read(REG_STATUS, 32'h1);
        irq_chk(1'h0);
        reg_wr(REG_ENABLE, 32'hf);
        irq_chk(1'h1);
        reg_wr(REG_CLEAR, 32'h1);
        irq_chk(1'h0);
        reg_read(REG_STATUS, 32'h0);
        $display("test slb done");
        delay = 8'h28;
        for (k = 0; k < 3; k++) run_op(OP_TLBI_GLOBAL, '0, {$urandom, $urandom}, 1'(k), 1'h1);
        reg_read(REG_PENDING, 32'h3);
        run_op(OP_TLB_SYNC, '0, '0, 1'h0, 1'h1);
        reg_read(REG_PENDING, 32'h0);
        delay = 8'h01;
        run_op(OP_TLBI_GLOBAL, '0, {$urandom, $urandom}, 1'h1, 1'h1);
        run_op(OP_TLB_SYNC, '0, '0, 1'h0, 1'h1);
        x = {$urandom, 32'h0};
        run_op(OP_TLBI_LOCAL, '0, x, 1'h1, 1'h1);
        chk_result({12'h000, o_tlb_vpn}, x >> VPN_LSB);
        run_op(OP_TLBI_ALL, '0, '0, 1'h0, 1'h1);
        run_op(OP_TLBI_GLOBAL, '0, '0, 1'h0, 1'h0);
        reg_read(REG_STATUS, 32'h7);
        reg_wr(REG_CLEAR, 32'hf);
        $display("test tlb done");
        reg_wr(REG_CONFIG, 32'h1);
        run_op(OP_TLBI_LOCAL, '0, {$urandom, 32'h0}, 1'h1, 1'h1);
        reg_wr(REG_CONFIG, 32'h2);
        for (k = 4; k < 8; k++) run_op(8'(k), '0, '0, 1'h1, 1'h1);
        reg_read(REG_STATUS, 32'h8);
        reg_wr(REG_CLEAR, 32'hf);
        reg_wr(REG_CONFIG, 32'h0);
        for (k = 4; k < 8; k++) run_op(8'(k), '0, '0, 1'h1, 1'h1);
        reg_read(REG_STATUS, 32'h0);
        reg_wr(REG_CONFIG, 32'h0000_0005);
        reg_read(REG_CONFIG, 32'h0000_0005);
        $display("test absent done");
        complete_run();
    end
endmodule : lookaside_buffer_maintenance_tb
bind lookaside_buffer_maintenance lbm_assertions chk (.*);
